// ### testbench/ctrl_model.sv
// Controller model that drives the command buffer's address/command pins.
// Assumes requests change just after a rising edge; pins move on falling edges.
`timescale 1ns/1ps
module ctrl_model
  import regbuf_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [DATA_W-1:0] word,
  input  wire logic [1:0]        cs_req,
  input  wire logic              bad,
  output logic [DATA_W-1:0]      data_in,
  output logic                   chip_select_in_0,
  output logic                   chip_select_in_1,
  output logic                   parity_bit_in
);
  // ==========================================================================
  // Pin driver
  // ==========================================================================
  logic bad_d;

  // Parity trails its word by one cycle, so it is formed from the word still
  // on the pins; every data bit is always driven to a known level.
  always @(negedge mclk) begin
    data_in          <= word;
    chip_select_in_0 <= cs_req[0];
    chip_select_in_1 <= cs_req[1];
    parity_bit_in    <= ^data_in ^ bad_d;
    bad_d            <= bad;
  end

  // Pins start idle and deselected so nothing is checked before use.
  initial begin
    data_in          = '0;
    chip_select_in_0 = 1'b1;
    chip_select_in_1 = 1'b1;
    parity_bit_in    = 1'b0;
    bad_d            = 1'b0;
  end
endmodule // ctrl_model

// ### testbench/regbuf_top_test.sv
// Self-checking bench for the registered command buffer with parity check.
// Assumes the design package is compiled first and the pin pulls up when
// the fault enable is low.
`timescale 1ns/1ps
module regbuf_top_test;
  import regbuf_pkg::*;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic              mclk = 0;
  logic              nrst = 0;
  logic [1:0]        cke = '0;
  logic [1:0]        odt = '0;
  logic              gate = 0;
  logic [DATA_W-1:0] word_r = '0;
  logic [1:0]        cs_r = 2'h3;
  logic              bad_r = 0;
  logic [DATA_W-1:0] data_in;
  logic              cs0, cs1, par;
  bank_t             bank_a_outputs, bank_b_outputs;
  logic              fault_out, fault_oe;
  int                n_errors = 0;
  int                tests_run = 0;

  always #2 mclk = ~mclk;

  ctrl_model ctrl_model_i (.mclk(mclk), .word(word_r), .cs_req(cs_r), .bad(bad_r),
    .data_in(data_in), .chip_select_in_0(cs0), .chip_select_in_1(cs1), .parity_bit_in(par));

  regbuf_top regbuf_top_i (.mclk(mclk), .nrst(nrst), .ce(1'b1), .data_in(data_in),
    .chip_select_in_0(cs0), .chip_select_in_1(cs1), .clk_enable_in_0(cke[0]),
    .clk_enable_in_1(cke[1]), .termination_in_0(odt[0]), .termination_in_1(odt[1]),
    .select_gate_enable(gate), .parity_bit_in(par), .bank_a_outputs(bank_a_outputs),
    .bank_b_outputs(bank_b_outputs), .parity_fault_n_out(fault_out),
    .parity_fault_n_oe(fault_oe));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task print_verdict;
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One word, then idle; data shows after edge 2, a fault on edges 5 and 6.
  task automatic run(input logic [21:0] w, input logic [1:0] cs, input logic b,
                     input logic err, input logic [21:0] exp_d);
    @(posedge mclk); #1; word_r = w; cs_r = cs; bad_r = b;
    @(posedge mclk); #1; cs_r = 2'h3; bad_r = 1'b0;
    for (int k = 1; k <= 7; k++) begin
      @(posedge mclk); #1;
      if (k == 2) begin
        check(bank_a_outputs.data, exp_d);
        check(bank_b_outputs.data, exp_d);
      end
      check(fault_oe, err && (k == 5 || k == 6));
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_capture;
    @(negedge mclk); gate = 1; cke = 2'h1; odt = 2'h2;
    run(22'h200000, 2'h2, 0, 0, 22'h200000);
    check(bank_a_outputs.clk_enable, 2'h1);
    check(bank_b_outputs.termination, 2'h2);
    check(fault_out, 1'b0);
  endtask

  task t_gate_holds;
    @(negedge mclk); cke = 2'h2;
    run(22'h155555, 2'h3, 1, 0, 22'h200000);
    check(bank_a_outputs.clk_enable, 2'h2);
    check(bank_a_outputs.chip_select, 2'h3);
  endtask

  task t_ungated;
    @(negedge mclk); gate = 0;
    run(22'h0aaaaa, 2'h3, 0, 0, 22'h0aaaaa);
  endtask

  task t_fault;
    @(negedge mclk); gate = 1;
    run(22'h000001, 2'h1, 1, 1, 22'h000001);
    @(negedge mclk); gate = 0;
    run(22'h000003, 2'h2, 1, 1, 22'h000003);
    run(22'h3fffff, 2'h0, 1, 0, 22'h3fffff);
  endtask

  task t_reset_mid;
    @(posedge mclk); #1; word_r = 22'h000004; cs_r = 2'h2; bad_r = 1;
    @(posedge mclk); #1; cs_r = 2'h3; bad_r = 0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    check(fault_oe, 1'b1);
    nrst = 0;
    #1;
    check(fault_oe, 1'b0);
    check(bank_a_outputs, '0);
    repeat (3) @(negedge mclk);
    nrst = 1;
    repeat (5) @(posedge mclk);
  endtask

  // Main sequence: reset held 20 cycles, then each scenario in turn.
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    check(fault_oe, 1'b0);
    check(bank_b_outputs, '0);
    @(negedge mclk); nrst = 1;
    repeat (5) @(posedge mclk);
    t_capture();
    t_gate_holds();
    t_ungated();
    t_fault();
    t_reset_mid();
    print_verdict();
  end

  // Cuts a hang short and reports it as a failure.
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule // regbuf_top_test

// ### verilog/parity_checker.sv
// Delayed parity checker: compares captured data with a parity bit that
// arrives one cycle later, and drives an active-low fault pulse.
// Assumes inputs are already synchronised and reset is the released copy.
`timescale 1ns/1ps
module parity_checker
  import regbuf_pkg::*;
#(
  parameter int DATA_W = 22
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic [DATA_W-1:0] data,
  input  wire logic              one_select,
  input  wire logic              parity_bit_in,
  output logic                   parity_fault_n
);
  import regbuf_pkg::*;

  // ==========================================================================
  // Pipeline of the data parity and of the check qualifier
  // ==========================================================================
  logic       data_par;
  logic       check_due;
  logic       mismatch;
  logic       mismatch_due;
  logic [1:0] hold;

  // Data parity is kept until the parity bit arrives one cycle later.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_par  <= 1'b0;
      check_due <= 1'b0;
    end else if (ce) begin
      data_par  <= ^data;
      check_due <= one_select;
    end
  end

  // Mismatch is evaluated, then reported one extra cycle later.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mismatch     <= 1'b0;
      mismatch_due <= 1'b0;
    end else if (ce) begin
      mismatch     <= data_par ^ parity_bit_in;
      mismatch_due <= check_due;
    end
  end

  // Fault output is held low for two cycles per error; a new error restarts it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold           <= HOLD_RESET;
      parity_fault_n <= FAULT_N_IDLE;
    end else if (ce) begin
      if (mismatch_due && mismatch) begin
        hold           <= 2'(FAULT_CYCLES - 1);
        parity_fault_n <= 1'b0;
      end else if (hold != HOLD_RESET) begin
        hold           <= hold - 2'h1;
      end else begin
        parity_fault_n <= FAULT_N_IDLE;
      end
    end
  end

  // A detected error pulls the output low for at least two cycles.
  fault_two_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    $fell(parity_fault_n) |-> !parity_fault_n [*2])
    else $error("fault output shorter than two cycles");

endmodule // parity_checker

// ### verilog/regbuf_pkg.sv
// Package for the registered command buffer with delayed parity check.
// Assumes a single clock domain; used by both design files.
package regbuf_pkg;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int         DATA_W        = 22;
  localparam int         FAULT_CYCLES  = 2;
  localparam logic [1:0] HOLD_RESET    = 2'h0;
  localparam logic       FAULT_N_IDLE  = 1'h1;

  // One copy of every registered output; each bank carries one of these.
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0]        chip_select;
    logic [1:0]        clk_enable;
    logic [1:0]        termination;
  } bank_t;

  localparam bank_t BANK_RESET = '0;

  // Parity checker states.
  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_WAIT = 2'b01,
    CHK_HOLD = 2'b10
  } chk_state_t;

endpackage

// ### verilog/regbuf_top.sv
// Top of the 1:2 registered command buffer with delayed parity check.
// Assumes all pin inputs are asynchronous to mclk and are synchronised here;
// the open-drain fault pin is resolved outside from the enable.
`timescale 1ns/1ps

// Operation
// - Parity is computed over all 22 data inputs and compared with the parity bit.
// - A parity mismatch on a word with exactly one chip select low pulls the open-drain fault output low, else it is released.
// - Each detected error keeps the fault output low for two cycles.
// - The error is reported one extra cycle after the mismatch is evaluated.
// - With the gate enable high, data is captured only when a chip select is low.
// - With the gate enable low, data is captured on every rising edge.
// - All captures happen on the rising clock edge and outputs hold between edges.
// - The asynchronous active-low reset clears all storage but the checker's fault flop, which it sets high, and drives outputs low.
// - Reset also clears any pending error and releases the fault output.
// - A low fault output stays low for two cycles unless reset releases it.
// - The gate enable has no effect on parity checking or the fault output.
// - Clock-enable and termination inputs are registered on every edge, ungated.
module regbuf_top
  import regbuf_pkg::*;
#(
  parameter int DATA_W = regbuf_pkg::DATA_W
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              chip_select_in_0,
  input  wire logic              chip_select_in_1,
  input  wire logic              clk_enable_in_0,
  input  wire logic              clk_enable_in_1,
  input  wire logic              termination_in_0,
  input  wire logic              termination_in_1,
  input  wire logic              select_gate_enable,
  input  wire logic              parity_bit_in,
  output regbuf_pkg::bank_t      bank_a_outputs,
  output regbuf_pkg::bank_t      bank_b_outputs,
  output logic                   parity_fault_n_out,
  output logic                   parity_fault_n_oe
);
  import regbuf_pkg::*;

  // ==========================================================================
  // Reset release and input synchronisers
  // ==========================================================================
  localparam int IN_W = DATA_W + 8;

  logic            rst_meta;
  logic            rst_n;
  logic [IN_W-1:0] in_meta;
  logic [IN_W-1:0] in_sync;

  // Reset asserts at once and releases through two flops.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Every pin passes two flops; only the second stage is read by logic.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta <= '0;
      in_sync <= '0;
    end else if (ce) begin
      in_meta <= {parity_bit_in, select_gate_enable, termination_in_1,
                  termination_in_0, clk_enable_in_1, clk_enable_in_0,
                  chip_select_in_1, chip_select_in_0, data_in};
      in_sync <= in_meta;
    end
  end

  logic [DATA_W-1:0] d_s;
  logic [1:0]        cs_s;
  logic [1:0]        cke_s;
  logic [1:0]        odt_s;
  logic              gate_s;
  logic              par_s;

  assign d_s    = in_sync[DATA_W-1:0];
  assign cs_s   = in_sync[DATA_W+1:DATA_W];
  assign cke_s  = in_sync[DATA_W+3:DATA_W+2];
  assign odt_s  = in_sync[DATA_W+5:DATA_W+4];
  assign gate_s = in_sync[DATA_W+6];
  assign par_s  = in_sync[DATA_W+7];

  // ==========================================================================
  // Output banks
  // ==========================================================================
  logic  capture;
  bank_t next_bank;

  // Gating saves output toggling when no rank is selected.
  assign capture = !gate_s || (cs_s != 2'b11);

  always_comb begin
    next_bank             = bank_a_outputs;
    next_bank.chip_select = cs_s;
    next_bank.clk_enable  = cke_s;
    next_bank.termination = odt_s;
    if (capture) begin
      next_bank.data = d_s;
    end
  end

  // Both banks load from one next value so they always match.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_a_outputs <= BANK_RESET;
      bank_b_outputs <= BANK_RESET;
    end else if (ce) begin
      bank_a_outputs <= next_bank;
      bank_b_outputs <= next_bank;
    end
  end

  // ==========================================================================
  // Parity check and open-drain fault pin
  // ==========================================================================
  logic fault_n;
  logic one_select;

  // Check only when exactly one select is low, whatever the gate enable.
  assign one_select = (cs_s == 2'b01) || (cs_s == 2'b10);

  parity_checker #(
    .DATA_W (DATA_W)
  ) parity_checker_i (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .ce             (ce),
    .data           (d_s),
    .one_select     (one_select),
    .parity_bit_in  (par_s),
    .parity_fault_n (fault_n)
  );

  // Pin output is a constant low; the enable flop decides pull-down.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      parity_fault_n_out <= 1'b0;
      parity_fault_n_oe  <= 1'b0;
    end else if (ce) begin
      parity_fault_n_out <= 1'b0;
      parity_fault_n_oe  <= !fault_n;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence gated_idle_s;
    gate_s && (cs_s == 2'b11);
  endsequence

  bank_hold_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    gated_idle_s |=> $stable(bank_a_outputs.data))
    else $error("data changed while gated off");

  bank_load_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    !gate_s |=> bank_a_outputs.data == $past(d_s))
    else $error("ungated data not captured");

  banks_same_a: assert property (@(posedge mclk) disable iff (!rst_n)
    bank_a_outputs == bank_b_outputs)
    else $error("bank copies differ");

  ungated_ctrl_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    1'b1 |=> bank_b_outputs.clk_enable == $past(cke_s))
    else $error("clock-enable copy not registered");

  sequence bad_word_s;
    one_select ##1 (parity_checker_i.data_par != par_s);
  endsequence

  // Mismatch flop, fault flop and pin flop add three edges after the parity edge.
  fault_delay_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    bad_word_s |-> ##3 parity_fault_n_oe [*2])
    else $error("fault not raised with expected delay");

  // A word without exactly one select must never start a new fault pulse.
  no_check_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    !one_select |-> ##4 !$rose(parity_fault_n_oe))
    else $error("fault raised for an unchecked word");

  reset_release_a: assert property (@(posedge mclk)
    !rst_n |-> !parity_fault_n_oe && bank_a_outputs == BANK_RESET)
    else $error("outputs not cleared in reset");

  fault_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    $rose(parity_fault_n_oe) |-> parity_fault_n_oe [*2])
    else $error("fault released early");

endmodule // regbuf_top
